// [verilog/hf_generic_envelope_quantizer.v]
/*
 holds the generic-mode excitation classifier and high-band envelope quantizer.
 assumes coefficient and envelope streams synchronous to clk_sys and a
 combinational codebook read: cb_data follows cb_stage/cb_addr in the same cycle.
*/
// Function
// - speech class when speech minus music likelihood exceeds one half
// - decision uses the raw per-frame classifier result, no hang-over
// - tonality only for music: mean of peak-to-mean band ratios in dB
// - tonality threshold splits noisy music from tonal music
// - class codes: noisy 00, tonal 01, speech single bit 1
// - low-band envelope has 27 bands low rate, 30 high rate
// - low band ends near 8 or 9.6 kHz where high band starts
// - swb high-band vector 14 elements low rate, 12 high rate
// - fullband adds three extra band energies up to 20 kHz
// - simulated spectrum copied with the fixed source-to-destination map
// - low rate keeps the non-transient quantizer, high rate multi-stage
// - first stage keeps three best candidates by squared error
// - first stage: 5-bit codebook on even positions plus position 11
// - residuals split three and four, reconstructions joined again
// - odd positions predicted from neighbour reconstructions, first uses its own
// - prediction error halves each use a 5-bit three-element codebook
// - fullband extra energies minus mean vector, then 5-bit quantized
// - five indices for high-rate swb, one extra index for fullband, the only one at low rate
// - tonality bands start at 320 or 384, widths 16 and 24
`timescale 1ns/1ps
`default_nettype none
`include "hf_generic_consts.vh"
module hf_generic_envelope_quantizer #(
   parameter signed [15:0] TONAL_THR = 16'sh0060
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire ce,
   input wire frame_start,
   input wire high_rate,
   input wire fullband,
   input wire signed [15:0] ls,
   input wire signed [15:0] lm,
   input wire coef_valid,
   input wire signed [15:0] coef_data,
   input wire env_valid,
   input wire signed [15:0] env_data,
   input wire signed [15:0] env_mean,
   input wire signed [15:0] cb_data,
   output reg [2:0] cb_stage,
   output reg [7:0] cb_addr,
   output reg copy_valid,
   output reg [9:0] copy_src,
   output reg [9:0] copy_dst,
   output reg busy,
   output reg frame_done,
   output reg [1:0] class_code,
   output reg [1:0] class_len,
   output reg [4:0] low_band_count,
   output reg [9:0] hb_start,
   output reg [9:0] hb_stop,
   output reg [4:0] hb_len,
   output reg [7:0] energy_control_gain,
   output reg [4:0] ec_bands,
   output reg [4:0] idx_s1,
   output reg [4:0] idx_s1_alt1,
   output reg [4:0] idx_s1_alt2,
   output reg [4:0] idx_err21,
   output reg [4:0] idx_err22,
   output reg [4:0] idx_pred31,
   output reg [4:0] idx_pred32,
   output reg [4:0] fullband_extra_energy_index,
   output reg [2:0] idx_count
);
   localparam [3:0] ST_IDLE = 4'h0, ST_LOAD = 4'h1, ST_CLASS = 4'h2, ST_COPY = 4'h3;
   localparam [3:0] ST_SETUP = 4'h4, ST_SRCH = 4'h5, ST_RECON = 4'h6, ST_NEXT = 4'h7;
   localparam [3:0] ST_DONE = 4'h8;

   // q4 log2, leading one plus four mantissa bits
   function [9:0] log2q;
      input [39:0] x;
      integer i;
      reg [5:0] p;
      reg [39:0] y;
      begin
         p = 6'h00;
         for (i = 0; i < 40; i = i + 1) begin
            if (x[i]) p = i[5:0];
         end
         y = x << (6'h27 - p);
         log2q = {p, y[38:35]};
      end
   endfunction

   reg [3:0] state;
   reg hr, fb, music;
   reg signed [15:0] ls_q, lm_q;
   reg [9:0] cidx, flen;
   reg [4:0] ecnt, elen;
   reg cdone, edone;
   reg signed [15:0] g [0:16];
   reg signed [15:0] mean_q;
   reg [3:0] tb, nb;
   reg [4:0] bpos;
   reg [31:0] peak;
   reg [39:0] bsum;
   reg signed [13:0] tacc;
   reg [2:0] stg, dim, ei;
   reg [4:0] ci;
   reg signed [17:0] t [0:6];
   reg signed [17:0] r [0:6];
   reg [39:0] acc, b0, b1, b2;
   reg [4:0] i0, i1, i2;
   integer k;

   // tonality band bookkeeping on the live coefficient
   wire [9:0] hbs = hr ? `HB_START_HI : `HB_START_LO;
   wire [4:0] bw = (tb < `TON_NARROW_LAST && !tb[0]) ? `W_NARROW : `W_WIDE;
   wire in_band = coef_valid && !cdone && cidx >= hbs && tb < nb && music;
   wire signed [31:0] csq_s = coef_data * coef_data; // full 32-bit product
   wire [31:0] csq = csq_s;
   wire [31:0] next_peak = (bpos == 5'h00 || csq > peak) ? csq : peak;
   wire [39:0] next_bsum = (bpos == 5'h00 ? 40'h0 : bsum) + {8'h00, csq};
   wire [9:0] log_w = (bw == `W_NARROW) ? `LOG2_W16 : `LOG2_W24;
   wire signed [13:0] band_db = $signed({4'h0, log2q({8'h00, next_peak})})
      + $signed({4'h0, log_w}) - $signed({4'h0, log2q(next_bsum)});
   // db sum in q4 against threshold times band count, avoids a divider
   wire signed [24:0] tdb = (tacc * $signed({1'b0, `TEN_LOG10_2})) >>> 8;
   wire signed [20:0] tthr = TONAL_THR * $signed({1'b0, nb});
   wire tonal = $signed({{1{tdb[24]}}, tdb}) > $signed({{5{tthr[20]}}, tthr});
   wire signed [16:0] ldiff = ls_q - lm_q;

   // search datapath: one codebook element per cycle
   wire signed [18:0] diff = t[ei] - cb_data;
   wire signed [37:0] dsq = diff * diff;
   wire [39:0] next_acc = (ei == 3'h0 ? 40'h0 : acc) + {2'b00, $unsigned(dsq)};

   // stage targets from envelope and earlier reconstructions
   reg signed [17:0] ev [0:11];
   reg signed [17:0] pe [0:5];
   reg signed [17:0] tg [0:6];
   reg signed [18:0] pair;
   always @* begin
      pair = 19'sh0;
      for (k = 0; k < 12; k = k + 1) begin
         ev[k] = mean_q - g[k];
      end
      pe[0] = ev[0] - r[0];
      for (k = 1; k < 6; k = k + 1) begin
         pair = r[k - 1] + r[k];
         pe[k] = ev[2 * k - 1] - pair[18:1];
      end
      for (k = 0; k < 7; k = k + 1) begin
         tg[k] = 18'sh0;
      end
      case (stg)
         3'h0: begin
            for (k = 0; k < 6; k = k + 1) tg[k] = ev[2 * k];
            tg[6] = ev[11];
         end
         3'h1: begin
            for (k = 0; k < 3; k = k + 1) tg[k] = ev[2 * k] - r[k];
         end
         3'h2: begin
            for (k = 0; k < 3; k = k + 1) tg[k] = ev[2 * (k + 3)] - r[k + 3];
            tg[3] = ev[11] - r[6];
         end
         3'h3: begin
            for (k = 0; k < 3; k = k + 1) tg[k] = pe[k];
         end
         3'h4: begin
            for (k = 0; k < 3; k = k + 1) tg[k] = pe[k + 3];
         end
         default: begin
            tg[0] = g[hb_len] - `FB_MEAN0;
            tg[1] = g[hb_len + 5'h01] - `FB_MEAN1;
            tg[2] = g[hb_len + 5'h02] - `FB_MEAN2;
         end
      endcase
   end

   // frame sequencer
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         hr <= 1'b0; fb <= 1'b0; music <= 1'b0;
         ls_q <= 16'sh0; lm_q <= 16'sh0; mean_q <= 16'sh0;
         cidx <= 10'h0; flen <= 10'h0; ecnt <= 5'h0; elen <= 5'h0;
         cdone <= 1'b0; edone <= 1'b0;
         tb <= 4'h0; nb <= 4'h0; bpos <= 5'h0; peak <= 32'h0; bsum <= 40'h0;
         tacc <= 14'sh0;
         stg <= 3'h0; dim <= 3'h0; ei <= 3'h0; ci <= 5'h0; acc <= 40'h0;
         b0 <= 40'h0; b1 <= 40'h0; b2 <= 40'h0; i0 <= 5'h0; i1 <= 5'h0; i2 <= 5'h0;
         for (k = 0; k < 17; k = k + 1) g[k] <= 16'sh0;
         for (k = 0; k < 7; k = k + 1) begin
            t[k] <= 18'sh0;
            r[k] <= 18'sh0;
         end
         cb_stage <= 3'h0; cb_addr <= 8'h0;
         copy_valid <= 1'b0; copy_src <= 10'h0; copy_dst <= 10'h0;
         busy <= 1'b0; frame_done <= 1'b0;
         class_code <= `CODE_NOISY; class_len <= `LEN_MUSIC;
         low_band_count <= 5'h0; hb_start <= 10'h0; hb_stop <= 10'h0; hb_len <= 5'h0;
         energy_control_gain <= `EC_GAIN; ec_bands <= 5'h0;
         idx_s1 <= 5'h0; idx_s1_alt1 <= 5'h0; idx_s1_alt2 <= 5'h0;
         idx_err21 <= 5'h0; idx_err22 <= 5'h0; idx_pred31 <= 5'h0; idx_pred32 <= 5'h0;
         fullband_extra_energy_index <= 5'h0; idx_count <= 3'h0;
      end else if (ce) begin
         frame_done <= 1'b0;
         copy_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (frame_start) begin
                  // classifier values latched once per frame, unsmoothed
                  hr <= high_rate; fb <= fullband; ls_q <= ls; lm_q <= lm;
                  music <= !((ls - lm) > `SPEECH_MARGIN);
                  mean_q <= env_mean;
                  cidx <= 10'h0; ecnt <= 5'h0; cdone <= 1'b0; edone <= 1'b0;
                  flen <= fullband ? `FRAME_FB : `FRAME_SWB;
                  // swb vector length, three more for fullband
                  elen <= (high_rate ? `HB_LEN_HI : `HB_LEN_LO) + (fullband ? `FB_EXTRA : 5'h0);
                  nb <= high_rate ? `TON_BANDS_HI : `TON_BANDS_LO;
                  tb <= 4'h0; bpos <= 5'h0; tacc <= 14'sh0;
                  low_band_count <= high_rate ? `LB_CNT_HI : `LB_CNT_LO;
                  // high band begins where the low band stops
                  hb_start <= high_rate ? `HB_START_HI : `HB_START_LO;
                  hb_stop <= (fullband ? `FRAME_FB : `FRAME_SWB) - 10'h001;
                  hb_len <= high_rate ? `HB_LEN_HI : `HB_LEN_LO;
                  // energy control on swb bands only
                  ec_bands <= high_rate ? `HB_LEN_HI : `HB_LEN_LO;
                  energy_control_gain <= `EC_GAIN;
                  idx_s1 <= 5'h0; idx_s1_alt1 <= 5'h0; idx_s1_alt2 <= 5'h0;
                  idx_err21 <= 5'h0; idx_err22 <= 5'h0; idx_pred31 <= 5'h0;
                  idx_pred32 <= 5'h0; fullband_extra_energy_index <= 5'h0;
                  idx_count <= 3'h0;
                  for (k = 0; k < 7; k = k + 1) r[k] <= 18'sh0;
                  busy <= 1'b1;
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (coef_valid && !cdone) begin
                  cidx <= cidx + 10'h001;
                  if (cidx == flen - 10'h001) cdone <= 1'b1;
               end
               // tonality accumulated only for music frames
               if (in_band) begin
                  peak <= next_peak;
                  bsum <= next_bsum;
                  if (bpos == bw - 5'h01) begin
                     tacc <= tacc + band_db;
                     tb <= tb + 4'h1;
                     bpos <= 5'h0;
                  end else begin
                     bpos <= bpos + 5'h01;
                  end
               end
               if (env_valid && !edone) begin
                  g[ecnt] <= env_data;
                  ecnt <= ecnt + 5'h01;
                  if (ecnt == elen - 5'h01) edone <= 1'b1;
               end
               if (cdone && edone) state <= ST_CLASS;
            end
            ST_CLASS: begin
               if (ldiff > `SPEECH_MARGIN) begin
                  class_code <= `CODE_SPEECH;
                  class_len <= `LEN_SPEECH;
               end else begin
                  class_code <= tonal ? `CODE_TONAL : `CODE_NOISY;
                  class_len <= `LEN_MUSIC;
               end
               copy_dst <= hbs;
               copy_src <= `SRC_MAIN;
               copy_valid <= 1'b1;
               state <= ST_COPY;
            end
            ST_COPY: begin
               // copy map, one destination bin per cycle
               if (copy_dst == `DST_LAST) begin
                  if (hr) begin
                     stg <= 3'h0;
                     state <= ST_SETUP;
                  end else if (fb) begin
                     stg <= 3'h5;
                     state <= ST_SETUP;
                  end else begin
                     state <= ST_DONE;
                  end
               end else begin
                  copy_valid <= 1'b1;
                  copy_dst <= copy_dst + 10'h001;
                  if (!hr && copy_dst + 10'h001 == `DST_LO_SEG2) copy_src <= `SRC_ALT;
                  else if ((!hr && copy_dst + 10'h001 == `DST_LO_SEG1)
                           || (hr && copy_dst + 10'h001 == `DST_HI_SEG1)) copy_src <= `SRC_MAIN;
                  else copy_src <= copy_src + 10'h001;
               end
            end
            ST_SETUP: begin
               for (k = 0; k < 7; k = k + 1) t[k] <= tg[k];
               dim <= (stg == 3'h0) ? 3'h7 : (stg == 3'h2) ? 3'h4 : 3'h3;
               b0 <= {40{1'b1}}; b1 <= {40{1'b1}}; b2 <= {40{1'b1}};
               i0 <= 5'h0; i1 <= 5'h0; i2 <= 5'h0;
               ci <= 5'h0; ei <= 3'h0;
               cb_stage <= stg; cb_addr <= 8'h0;
               state <= ST_SRCH;
            end
            ST_SRCH: begin
               acc <= next_acc;
               if (ei == dim - 3'h1) begin
                  // three best kept, ties keep the earlier entry
                  if (next_acc < b0) begin
                     b0 <= next_acc; i0 <= ci; b1 <= b0; i1 <= i0; b2 <= b1; i2 <= i1;
                  end else if (next_acc < b1) begin
                     b1 <= next_acc; i1 <= ci; b2 <= b1; i2 <= i1;
                  end else if (next_acc < b2) begin
                     b2 <= next_acc; i2 <= ci;
                  end
                  ei <= 3'h0;
                  if (ci == `CB_LAST) begin
                     state <= ST_RECON;
                     cb_addr <= {(next_acc < b0) ? ci : i0, 3'h0};
                  end else begin
                     ci <= ci + 5'h01;
                     cb_addr <= {ci + 5'h01, 3'h0};
                  end
               end else begin
                  ei <= ei + 3'h1;
                  cb_addr <= {ci, ei + 3'h1};
               end
            end
            ST_RECON: begin
               // reconstructions joined into one seven-element error
               if (stg == 3'h0) r[ei] <= cb_data;
               else if (stg == 3'h1) r[ei] <= r[ei] + cb_data;
               else if (stg == 3'h2) r[ei + 3'h3] <= r[ei + 3'h3] + cb_data;
               if (ei == dim - 3'h1) begin
                  // index set grows stage by stage
                  case (stg)
                     3'h0: begin
                        idx_s1 <= i0; idx_s1_alt1 <= i1; idx_s1_alt2 <= i2;
                     end
                     3'h1: idx_err21 <= i0;
                     3'h2: idx_err22 <= i0;
                     3'h3: idx_pred31 <= i0;
                     3'h4: idx_pred32 <= i0;
                     default: fullband_extra_energy_index <= i0;
                  endcase
                  idx_count <= idx_count + 3'h1;
                  state <= ST_NEXT;
               end else begin
                  ei <= ei + 3'h1;
                  cb_addr <= {i0, ei + 3'h1};
               end
            end
            ST_NEXT: begin
               // multi-stage path only at the high rate
               if (stg == 3'h5 || (stg == 3'h4 && !fb)) begin
                  state <= ST_DONE;
               end else begin
                  stg <= (stg == 3'h4) ? 3'h5 : stg + 3'h1;
                  state <= ST_SETUP;
               end
            end
            ST_DONE: begin
               frame_done <= 1'b1;
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // hf_generic_envelope_quantizer
`default_nettype wire

// [verilog/hf_generic_consts.vh]
/*
 holds the constants of the generic-mode high-band envelope quantizer.
 assumes q8 fixed point for likelihoods and envelope values.
*/
`ifndef HF_GENERIC_CONSTS_VH
`define HF_GENERIC_CONSTS_VH
// class decision
`define SPEECH_MARGIN 17'sh00080
`define CODE_NOISY 2'h0
`define CODE_TONAL 2'h1
`define CODE_SPEECH 2'h1
`define LEN_MUSIC 2'h2
`define LEN_SPEECH 2'h1
// band layout
`define LB_CNT_LO 5'h1b
`define LB_CNT_HI 5'h1e
`define HB_START_LO 10'h140
`define HB_START_HI 10'h180
`define HB_LEN_LO 5'h0e
`define HB_LEN_HI 5'h0c
`define FB_EXTRA 5'h03
`define FRAME_SWB 10'h280
`define FRAME_FB 10'h320
`define TON_BANDS_LO 4'ha
`define TON_BANDS_HI 4'h8
`define TON_NARROW_LAST 4'h7
`define W_NARROW 5'h10
`define W_WIDE 5'h18
`define LOG2_W16 10'h040
`define LOG2_W24 10'h049
`define TEN_LOG10_2 11'h303
// energy control
`define EC_GAIN 8'h8d
// copy map
`define SRC_MAIN 10'h002
`define SRC_ALT 10'h050
`define DST_LO_SEG1 10'h1c0
`define DST_LO_SEG2 10'h240
`define DST_HI_SEG1 10'h200
`define DST_LAST 10'h27f
// vector quantizer
`define CB_LAST 5'h1f
`define FB_MEAN0 18'sh00dc0
`define FB_MEAN1 18'sh0064a
`define FB_MEAN2 18'sh003b3
`endif

// [verification/hf_codebook_model.sv]
/*
 codebook partner for the envelope quantizer tests.
 assumes the quantizer reads cb_data combinationally from cb_stage and cb_addr.
*/
`timescale 1ns/1ps
`default_nettype none
module hf_codebook_model (
   input wire logic [2:0] cb_stage,
   input wire logic [7:0] cb_addr,
   input wire logic [29:0] pick,
   output logic signed [15:0] cb_data
);
   // picked codeword is all zero, the rest sit far off so the search is unambiguous
   always_comb begin
      if (cb_stage > 3'h5)
         cb_data = {8'h5a, cb_addr}; // unused stages show a moving pattern
      else if (cb_addr[7:3] == pick[cb_stage * 5 +: 5])
         cb_data = 16'sh0000;
      else
         cb_data = 16'sh0400;
   end
endmodule // hf_codebook_model
`default_nettype wire

// [verification/hf_envelope_checker.sv]
/*
 port checker for the high-band envelope quantizer.
 assumes one clock and a synchronous active-high reset; bound onto the design.
*/
`timescale 1ns/1ps
`default_nettype none
module hf_envelope_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic frame_start,
   input wire logic busy,
   input wire logic frame_done,
   input wire logic [1:0] class_code,
   input wire logic [1:0] class_len,
   input wire logic [4:0] low_band_count,
   input wire logic [9:0] hb_start,
   input wire logic [4:0] hb_len,
   input wire logic [4:0] ec_bands,
   input wire logic [7:0] energy_control_gain,
   input wire logic copy_valid,
   input wire logic [9:0] copy_src,
   input wire logic [9:0] copy_dst,
   input wire logic [2:0] idx_count
);
   default clocking dclk @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_start_busy: assert property (frame_start && ce && !busy |=> busy)
      else $error("accepted frame did not raise busy");
   a_done_pulse: assert property (frame_done && ce |=> !frame_done)
      else $error("done stood longer than one cycle");
   a_done_idle: assert property (frame_done |-> !busy)
      else $error("done raised while busy");
   a_speech_code: assert property (class_len == 2'h1 |-> class_code == 2'h1)
      else $error("single bit class with wrong code");
   a_music_code: assert property (class_len != 2'h1 |->
      class_len == 2'h2 && !class_code[1])
      else $error("two bit class with wrong code");
   a_band_layout: assert property (frame_done |->
      (hb_start == 10'h140 && hb_len == 5'h0e && low_band_count == 5'h1b) ||
      (hb_start == 10'h180 && hb_len == 5'h0c && low_band_count == 5'h1e))
      else $error("band layout does not match rate");
   a_ec_span: assert property (frame_done |->
      ec_bands == hb_len && energy_control_gain == 8'h8d)
      else $error("energy control span or gain wrong");
   a_copy_range: assert property (copy_valid |->
      copy_dst >= hb_start && copy_dst <= 10'h27f)
      else $error("copy destination out of range");
   a_copy_src: assert property (copy_valid |-> copy_src == (hb_start == 10'h140 ?
      (copy_dst < 10'h1c0 ? copy_dst - 10'h13e :
      (copy_dst < 10'h240 ? copy_dst - 10'h1be : copy_dst - 10'h1f0)) :
      (copy_dst < 10'h200 ? copy_dst - 10'h17e : copy_dst - 10'h1fe)))
      else $error("copy source does not match destination");
   a_copy_step: assert property (copy_valid && ce && copy_dst != 10'h27f |=>
      copy_valid && copy_dst == $past(copy_dst) + 10'h001)
      else $error("copy destinations not consecutive");
   a_low_rate_idx: assert property (frame_done && hb_start == 10'h140 |->
      idx_count <= 3'h1)
      else $error("low rate produced stage indices");
   // main scenarios
   c_speech: cover property (frame_done && class_len == 2'h1);
   c_tonal: cover property (frame_done && class_len == 2'h2 && class_code == 2'h1);
   c_noisy: cover property (frame_done && class_len == 2'h2 && class_code == 2'h0);
   c_full: cover property (frame_done && idx_count == 3'h6);
endmodule // hf_envelope_checker
bind hf_generic_envelope_quantizer hf_envelope_checker u_hf_envelope_checker (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .frame_start(frame_start), .busy(busy),
   .frame_done(frame_done), .class_code(class_code), .class_len(class_len),
   .low_band_count(low_band_count), .hb_start(hb_start), .hb_len(hb_len),
   .ec_bands(ec_bands), .energy_control_gain(energy_control_gain), .copy_valid(copy_valid),
   .copy_src(copy_src), .copy_dst(copy_dst), .idx_count(idx_count)
);
`default_nettype wire

// [verification/hf_generic_envelope_quantizer_tb.sv]
/*
 self-checking bench for the high-band envelope quantizer.
 assumes the codebook partner answers combinationally; 50 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hf_generic_envelope_quantizer_tb;
   typedef struct {logic [1:0] code; logic [1:0] len; logic hr, fb; logic [29:0] pick;} note_t;
   note_t notes[$];
   note_t m;
   int bad_count = 0, checked = 0, ncopy = 0;
   logic [31:0] seed, r;
   logic clk_sys, sys_rst, ce, frame_start, high_rate, fullband, coef_valid, env_valid;
   logic signed [15:0] ls, lm, coef_data, env_data, env_mean;
   logic [29:0] pick;
   wire signed [15:0] cb_data;
   wire [2:0] cb_stage, idx_count;
   wire [7:0] cb_addr, energy_control_gain;
   wire [9:0] copy_src, copy_dst, hb_start, hb_stop;
   wire copy_valid, busy, frame_done;
   wire [1:0] class_code, class_len;
   wire [4:0] low_band_count, hb_len, ec_bands, idx_s1, idx_s1_alt1, idx_s1_alt2;
   wire [4:0] idx_err21, idx_err22, idx_pred31, idx_pred32, fullband_extra_energy_index;
   // threshold left at its 6 dB default; flat bands sit at 0 dB, peaky ones near 9 dB
   hf_generic_envelope_quantizer #(.TONAL_THR(16'sh0060)) u_hf_generic_envelope_quantizer (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .frame_start(frame_start),
      .high_rate(high_rate), .fullband(fullband), .ls(ls), .lm(lm), .coef_valid(coef_valid),
      .coef_data(coef_data), .env_valid(env_valid), .env_data(env_data), .env_mean(env_mean),
      .cb_data(cb_data), .cb_stage(cb_stage), .cb_addr(cb_addr), .copy_valid(copy_valid),
      .copy_src(copy_src), .copy_dst(copy_dst), .busy(busy), .frame_done(frame_done),
      .class_code(class_code), .class_len(class_len), .low_band_count(low_band_count),
      .hb_start(hb_start), .hb_stop(hb_stop), .hb_len(hb_len),
      .energy_control_gain(energy_control_gain), .ec_bands(ec_bands), .idx_s1(idx_s1),
      .idx_s1_alt1(idx_s1_alt1), .idx_s1_alt2(idx_s1_alt2), .idx_err21(idx_err21),
      .idx_err22(idx_err22), .idx_pred31(idx_pred31), .idx_pred32(idx_pred32),
      .fullband_extra_energy_index(fullband_extra_energy_index), .idx_count(idx_count));
   hf_codebook_model u_hf_codebook_model (.cb_stage(cb_stage), .cb_addr(cb_addr),
      .pick(pick), .cb_data(cb_data));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one frame: note the expectation, then stream coefficients and envelope together
   task automatic run_frame(input logic hr, input logic fb, input logic signed [15:0] sl,
         input logic signed [15:0] ml, input logic peaky, input logic [29:0] pk, input logic dup);
      note_t n;
      int k, hbs, nenv;
      logic signed [16:0] diff;
      logic [15:0] fbm [3];
      fbm = '{16'h0dc0, 16'h064a, 16'h03b3};
      hbs = hr ? 384 : 320;
      nenv = (hr ? 12 : 14) + (fb ? 3 : 0);
      diff = {sl[15], sl} - {ml[15], ml};
      n.hr = hr;
      n.fb = fb;
      n.pick = pk;
      n.len = (diff > 17'sh00080) ? 2'h1 : 2'h2;
      n.code = (n.len == 2'h1 || peaky) ? 2'h1 : 2'h0;
      notes.push_back(n);
      @(negedge clk_sys);
      frame_start = 1'b1;
      high_rate = hr;
      fullband = fb;
      pick = pk;
      env_mean = hr ? 16'sh0000 : seed[15:0];
      ls = sl;
      lm = ml;
      for (k = 0; k < 800; k++) begin
         @(negedge clk_sys);
         seed = xs(seed);
         frame_start = dup && (k == 100); // refused while busy
         coef_valid = k < (fb ? 800 : 640);
         if (!coef_valid)
            coef_data = ~coef_data;
         else if (k < hbs || n.len == 2'h1)
            coef_data = seed[15:0];
         else
            coef_data = peaky ? ((k % 8 == 0) ? 16'sh0400 : 16'sh0001) : 16'sh0100;
         env_valid = k < nenv;
         if (!env_valid)
            env_data = ~env_data;
         else
            env_data = (k >= nenv - 3 && fb) ? fbm[k - nenv + 3] : (hr ? 16'sh0 : seed[31:16]);
      end
      @(negedge clk_sys);
      coef_valid = 1'b0;
      env_valid = 1'b0;
      if (dup) begin
         repeat (20) @(negedge clk_sys);
         ce = 1'b0; // freeze in mid copy
         repeat (4) @(negedge clk_sys);
         ce = 1'b1;
      end
      k = 0;
      while (busy !== 1'b0 && k < 8000) begin
         @(negedge clk_sys);
         k++;
      end
      check(busy, 1'b0, "busy");
      $display("frame over hr %0d fb %0d", hr, fb);
   endtask
   // scoreboard: count copy beats, compare results on each done pulse
   always @(posedge clk_sys) begin
      if (!sys_rst && ce && copy_valid) begin
         if (ncopy == 0)
            check(copy_dst, notes[0].hr ? 384 : 320, "copy_dst");
         ncopy++;
      end
      if (!sys_rst && ce && frame_done && notes.size() > 0) begin
         m = notes.pop_front();
         check(class_code, m.code, "class_code");
         check(class_len, m.len, "class_len");
         check(low_band_count, m.hr ? 30 : 27, "low_band_count");
         check(hb_stop, m.fb ? 799 : 639, "hb_stop");
         check(ec_bands, m.hr ? 12 : 14, "ec_bands");
         check(ncopy, m.hr ? 256 : 320, "copy_count");
         check(idx_count, m.hr ? (m.fb ? 6 : 5) : (m.fb ? 1 : 0), "idx_count");
         check(idx_s1, m.hr ? m.pick[4:0] : 0, "idx_s1");
         check(idx_s1_alt1, m.hr ? (m.pick[4:0] == 0 ? 1 : 0) : 0, "alt1");
         check(idx_s1_alt2, m.hr ? (m.pick[4:0] <= 1 ? 2 : 1) : 0, "alt2");
         check(idx_err21, m.hr ? m.pick[9:5] : 0, "idx_err21");
         check(idx_err22, m.hr ? m.pick[14:10] : 0, "idx_err22");
         check(idx_pred31, m.hr ? m.pick[19:15] : 0, "idx_pred31");
         check(idx_pred32, m.hr ? m.pick[24:20] : 0, "idx_pred32");
         check(fullband_extra_energy_index, m.fb ? m.pick[29:25] : 0, "fullband_extra_energy_index");
         ncopy = 0;
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard, well beyond nine frames of about 1800 cycles
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      $display("Error watchdog expected done seen hang");
      close_out();
   end
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      {frame_start, high_rate, fullband, coef_valid, env_valid} = 5'h00;
      {ls, lm, coef_data, env_data, env_mean} = 80'h0;
      pick = 30'h0;
      seed = 34;
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      check(class_len, 2'h2, "reset_len");
      check(energy_control_gain, 8'h8d, "reset_gain");
      check(busy, 1'b0, "reset_busy");
      // margin just above and exactly at one half
      run_frame(0, 0, 16'sh0181, 16'sh0100, 1, 30'h0, 0);
      run_frame(0, 0, 16'sh0180, 16'sh0100, 0, 30'h0, 0);
      run_frame(0, 1, 16'sh0000, 16'sh0100, 1, {5'h1b, 25'h0}, 0);
      run_frame(1, 0, 16'sh0010, 16'sh0020, 0, {5'h0, 5'h4, 5'h3, 5'h2, 5'h1, 5'h7}, 1);
      run_frame(1, 1, -16'sh0040, 16'sh0020, 1, {5'h1f, 5'h1e, 5'h0, 5'h11, 5'h9, 5'h0}, 0);
      repeat (4) begin
         seed = xs(seed);
         r = seed;
         seed = xs(seed);
         run_frame(r[0], r[1], {6'h0, r[11:2]}, {6'h0, r[21:12]}, r[22], seed[29:0], 0);
      end
      repeat (2) @(negedge clk_sys);
      close_out();
   end
endmodule // hf_generic_envelope_quantizer_tb
`default_nettype wire
